// >>> ssl_drive_model.sv
// model of drive terminals and status signals
// assumes the bench commands the levels
`timescale 1ns/1ps
module ssl_drive_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // commanded levels
  input wire logic [ssl_pkg::SSL_NTERM-1:0] term_cmd,
  input wire logic [ssl_pkg::SSL_NSTAT-1:0] stat_cmd,
  // to the engine
  output logic [ssl_pkg::SSL_NTERM-1:0] term_in,
  output logic [ssl_pkg::SSL_NSTAT-1:0] status_in
);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      term_in <= '0;
      status_in <= '0;
    end else begin
      term_in <= term_cmd;
      status_in <= stat_cmd;
    end
  end
endmodule

// >>> ssl_engine.sv
// step sequence logic engine with apb register file
// assumes terminal and status inputs come from outside this clock domain
`timescale 1ns/1ps

// Behaviour
// - each step takes two selected inputs, one operation with timer, one output
// - ten independent steps chainable into one sequence
// - thirteen operation types and five timer types per step
// - five outputs, each with source select and function select
// - full pass of all steps and output update every 2 ms
// - mode 0 holds engine_out low (engine_out_function still follows function select), mode 1 enables the engine
// - step settings in order input1, input2, operation, timer type, timer value
// - monitor select picks which step timer value is reported
// - inputs select step outputs, terminals or drive status by numeric code
// - operation 0 holds output low, operation 2 ands inputs through timer
module ssl_engine (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive side
  input wire logic [ssl_pkg::SSL_NTERM-1:0] term_in,
  input wire logic [ssl_pkg::SSL_NSTAT-1:0] status_in,
  output logic [ssl_pkg::SSL_NOUT-1:0] engine_out,
  output logic [ssl_pkg::SSL_NOUT*8-1:0] engine_out_function,
  output logic engine_active
);
  import ssl_pkg::*;

  // ****************
  // registers
  // ****************
  logic engine_mode_setting;
  logic [15:0] step_cfg [SSL_NSTEP*5];
  logic [15:0] output_source_select [SSL_NOUT];
  logic [7:0] output_function_select [SSL_NOUT];
  logic [3:0] timer_monitor_step_select;
  logic [SSL_NTERM-1:0] term_meta, term_sync;
  logic [SSL_NSTAT-1:0] stat_meta, stat_sync;
  logic [SSL_NSTEP-1:0] step_result;
  logic [15:0] step_timer [SSL_NSTEP];
  logic [SSL_NSTEP-1:0] prev_a;
  logic [15:0] period_cnt;
  logic [3:0] step_idx;
  logic [15:0] tick_cnt;

  // ****************
  // bus decode
  // ****************
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [11:0] step_rel = paddr - SSL_STEP_BASE;
  wire [11:0] osrc_rel = paddr - SSL_OSRC_BASE;
  wire [11:0] ofun_rel = paddr - SSL_OFUN_BASE;
  wire hit_mode = paddr == SSL_MODE_OFF;
  wire hit_step = paddr >= SSL_STEP_BASE && step_rel < 12'(SSL_NSTEP*5*4);
  wire hit_osrc = paddr >= SSL_OSRC_BASE && osrc_rel < 12'(SSL_NOUT*4);
  wire hit_ofun = paddr >= SSL_OFUN_BASE && ofun_rel < 12'(SSL_NOUT*4);
  wire hit_msel = paddr == SSL_MONSEL_OFF;
  wire hit_mval = paddr == SSL_MONVAL_OFF;
  wire hit_stat = paddr == SSL_STATUS_OFF;
  wire aligned = paddr[1:0] == 2'b00;
  wire hit_any = aligned && (hit_mode || hit_step || hit_osrc || hit_ofun
                 || hit_msel || hit_mval || hit_stat);
  wire [5:0] step_w = step_rel[7:2];
  wire [2:0] osrc_w = osrc_rel[4:2];
  wire [2:0] ofun_w = ofun_rel[4:2];
  wire [3:0] mon_idx = (timer_monitor_step_select < 4'(SSL_NSTEP))
                       ? timer_monitor_step_select : 4'h0;
  wire [31:0] rd_val =
    !aligned ? 32'h0 :
    hit_mode ? {31'h0, engine_mode_setting} :
    hit_step ? {16'h0, step_cfg[step_w]} :
    hit_osrc ? {16'h0, output_source_select[osrc_w]} :
    hit_ofun ? {24'h0, output_function_select[ofun_w]} :
    hit_msel ? {28'h0, timer_monitor_step_select} :
    hit_mval ? {16'h0, step_timer[mon_idx]} :
    hit_stat ? {22'h0, step_result} : 32'h0;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      engine_mode_setting <= SSL_MODE_RST;
      timer_monitor_step_select <= 4'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !hit_any;
      prdata <= rd_val;
      if (wr && !pready && hit_mode && aligned) begin
        engine_mode_setting <= pwdata[0];
      end
      if (wr && !pready && hit_msel && aligned) begin
        timer_monitor_step_select <= pwdata[3:0];
      end
    end
  end

  // step settings: five consecutive words per step
  for (genvar g = 0; g < SSL_NSTEP*5; g++) begin : g_cfg
    always_ff @(posedge core_clk) begin
      if (reset) begin
        step_cfg[g] <= SSL_CFG_RST;
      end else if (wr && !pready && aligned && hit_step && step_w == 6'(g)) begin
        step_cfg[g] <= pwdata[15:0];
      end
    end
  end

  for (genvar o = 0; o < SSL_NOUT; o++) begin : g_ocfg
    always_ff @(posedge core_clk) begin
      if (reset) begin
        output_source_select[o] <= SSL_CFG_RST;
        output_function_select[o] <= 8'h00;
      end else begin
        if (wr && !pready && aligned && hit_osrc && osrc_w == 3'(o)) begin
          output_source_select[o] <= pwdata[15:0];
        end
        if (wr && !pready && aligned && hit_ofun && ofun_w == 3'(o)) begin
          output_function_select[o] <= pwdata[7:0];
        end
      end
    end
  end

  // ****************
  // input synchronisers
  // ****************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      term_meta <= '0;
      term_sync <= '0;
      stat_meta <= '0;
      stat_sync <= '0;
    end else begin
      term_meta <= term_in;
      term_sync <= term_meta;
      stat_meta <= status_in;
      stat_sync <= stat_meta;
    end
  end

  // ****************
  // signal selection
  // ****************
  function automatic logic pick(input logic [15:0] code, input logic [SSL_NSTEP-1:0] so,
                                input logic [SSL_NTERM-1:0] tm, input logic [SSL_NSTAT-1:0] st);
    logic [15:0] d;
    logic r;
    r = 1'b0;
    d = code - SSL_SEL_STEP;
    if (code >= SSL_SEL_STEP && d < 16'(SSL_NSTEP)) r = so[d[3:0]];
    d = code - SSL_SEL_TERM;
    if (code >= SSL_SEL_TERM && d < 16'(SSL_NTERM)) r = tm[d[3:0]];
    d = code - SSL_SEL_STAT;
    if (code >= SSL_SEL_STAT && d < 16'(SSL_NSTAT)) r = st[d[2:0]];
    return r;
  endfunction

  // ****************
  // sequential step evaluation
  // ****************
  wire pass_start = period_cnt == 16'(SSL_PERIOD_CYC - 1);
  wire stepping = step_idx < 4'(SSL_NSTEP);
  wire [3:0] si = stepping ? step_idx : 4'h0;
  wire [15:0] in1_code = step_cfg[si*5 + SSL_F_IN1];
  wire [15:0] in2_code = step_cfg[si*5 + SSL_F_IN2];
  wire [3:0] op = step_cfg[si*5 + SSL_F_OP][3:0];
  wire [2:0] tmode = step_cfg[si*5 + SSL_F_TMODE][2:0];
  wire [15:0] tval = step_cfg[si*5 + SSL_F_TVAL];
  wire in_a = pick(in1_code, step_result, term_sync, stat_sync);
  wire in_b = pick(in2_code, step_result, term_sync, stat_sync);
  wire pa = prev_a[si];
  wire cur = step_result[si];
  wire [15:0] tcur = step_timer[si];
  // logic stage
  wire logic_out =
    op == SSL_OP_OFF ? 1'b0 :
    op == SSL_OP_THRU ? in_a :
    op == SSL_OP_AND ? (in_a & in_b) :
    op == SSL_OP_OR ? (in_a | in_b) :
    op == SSL_OP_XOR ? (in_a ^ in_b) :
    op == SSL_OP_SRST ? (in_a | (cur & !in_b)) :
    op == SSL_OP_RSET ? (!in_b & (in_a | cur)) :
    op == SSL_OP_RISE ? (in_a & !pa) :
    op == SSL_OP_FALL ? (!in_a & pa) :
    op == SSL_OP_EDGE ? (in_a ^ pa) :
    op == SSL_OP_NAND ? !(in_a & in_b) :
    op == SSL_OP_NOR ? !(in_a | in_b) :
    op == SSL_OP_CNT ? 1'b0 : 1'b0;
  // counter mode: in_a rising counts, in_b clears, output at tval
  wire [15:0] cnt_next = in_b ? 16'h0 : ((in_a & !pa && tcur != 16'hffff) ? tcur + 16'h1 : tcur);
  wire t_done = tcur >= tval;
  wire [15:0] t_inc = t_done ? tcur : tcur + 16'h1;
  // timer stage, timer counts in pass periods
  wire [15:0] next_timer =
    op == SSL_OP_CNT ? cnt_next :
    tmode == SSL_TM_ON ? (logic_out ? t_inc : 16'h0) :
    tmode == SSL_TM_OFF ? (logic_out ? 16'h0 : t_inc) :
    tmode == SSL_TM_PULSE ? ((logic_out & !cur & tcur == 16'h0) ? 16'h1 :
                             (cur ? t_inc : 16'h0)) :
    tmode == SSL_TM_RETRIG ? (logic_out ? 16'h1 : (cur ? t_inc : 16'h0)) : 16'h0;
  wire next_result =
    op == SSL_OP_OFF ? 1'b0 :
    op == SSL_OP_CNT ? (cnt_next >= tval) :
    tmode == SSL_TM_NONE ? logic_out :
    tmode == SSL_TM_ON ? (logic_out & next_timer >= tval) :
    tmode == SSL_TM_OFF ? (logic_out | (next_timer < tval)) :
    tmode == SSL_TM_PULSE ? (next_timer != 16'h0 && next_timer <= tval) :
    tmode == SSL_TM_RETRIG ? (next_timer != 16'h0 && next_timer <= tval) : 1'b0;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      period_cnt <= 16'h0;
      step_idx <= 4'(SSL_NSTEP);
    end else begin
      period_cnt <= pass_start ? 16'h0 : period_cnt + 16'h1;
      if (pass_start) begin
        step_idx <= 4'h0;
      end else if (stepping) begin
        step_idx <= step_idx + 4'h1;
      end
    end
  end

  for (genvar s = 0; s < SSL_NSTEP; s++) begin : g_step
    always_ff @(posedge core_clk) begin
      if (reset) begin
        step_result[s] <= 1'b0;
        step_timer[s] <= 16'h0;
        prev_a[s] <= 1'b0;
      end else if (stepping && step_idx == 4'(s)) begin
        step_result[s] <= next_result;
        step_timer[s] <= next_timer;
        prev_a[s] <= in_a;
      end
    end
  end

  // ****************
  // output channels
  // ****************
  function automatic logic next_result_or(input logic [3:0] k);
    return (k == step_idx) ? next_result : step_result[k];
  endfunction

  wire pass_end = step_idx == 4'(SSL_NSTEP - 1);
  for (genvar o = 0; o < SSL_NOUT; o++) begin : g_out
    wire [15:0] d = output_source_select[o] - SSL_SEL_STEP;
    wire ok = output_source_select[o] >= SSL_SEL_STEP && d < 16'(SSL_NSTEP);
    always_ff @(posedge core_clk) begin
      if (reset) begin
        engine_out[o] <= 1'b0;
        engine_out_function[o*8 +: 8] <= 8'h00;
      end else begin
        engine_out_function[o*8 +: 8] <= output_function_select[o];
        if (!engine_mode_setting) begin
          engine_out[o] <= 1'b0;
        end else if (pass_end) begin
          engine_out[o] <= ok ? next_result_or(d[3:0]) : 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      engine_active <= 1'b0;
    end else begin
      engine_active <= engine_mode_setting;
    end
  end
endmodule

// >>> ssl_engine_assertions.sv
// checker for the step sequence engine ports
// assumes binding to ssl_engine with one clock and sync reset
`timescale 1ns/1ps
module ssl_engine_checker
  import ssl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // drive side
  input wire logic [ssl_pkg::SSL_NOUT-1:0] engine_out,
  input wire logic engine_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ************
  // pass spacing
  // ************
  int unsigned gap;
  logic armed;
  always_ff @(posedge core_clk) begin
    if (reset || !engine_active) begin
      gap <= 0;
      armed <= 1'b0;
    end else if ($changed(engine_out)) begin
      gap <= 0;
      armed <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("ready missing after access");
  a_ready_idle: assert property (!psel |=> !pready)
    else $error("ready without request");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_reset_quiet: assert property ($fell(reset) |-> engine_out == '0 && !engine_active)
    else $error("outputs not cleared by reset");
  a_off_zero: assert property (!engine_active [*2] |-> engine_out == '0)
    else $error("output while disabled");
  a_mode_copy: assert property (psel && penable && pwrite && !pready && paddr == SSL_MODE_OFF
    |-> ##[1:2] engine_active == pwdata[0])
    else $error("mode copy wrong");
  a_pass_period: assert property ($changed(engine_out) && engine_active && armed
    |-> gap % 20000 == 19999)
    else $error("output change off pass boundary");
  c_refused: cover property (pslverr);
  c_enable: cover property ($rose(engine_active));
  c_out: cover property ($rose(engine_out[0]));
endmodule
bind ssl_engine ssl_engine_checker u_ssl_engine_checker (.core_clk(core_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .engine_out(engine_out),
  .engine_active(engine_active));

// >>> ssl_pkg.sv
// package for the step sequence logic engine
// assumes a 10 mhz core clock and an apb register port
package ssl_pkg;
  localparam int unsigned SSL_NSTEP = 10;
  localparam int unsigned SSL_NOUT = 5;
  localparam int unsigned SSL_NTERM = 11;
  localparam int unsigned SSL_NSTAT = 8;
  // timing
  localparam int unsigned SSL_CLK_HZ = 10000000;
  localparam int unsigned SSL_PERIOD_US = 2000;
  localparam int unsigned SSL_PERIOD_CYC = SSL_CLK_HZ / 1000000 * SSL_PERIOD_US;
  // register byte offsets
  localparam logic [11:0] SSL_MODE_OFF = 12'h000;
  localparam logic [11:0] SSL_STEP_BASE = 12'h100;
  localparam logic [11:0] SSL_OSRC_BASE = 12'h200;
  localparam logic [11:0] SSL_OFUN_BASE = 12'h220;
  localparam logic [11:0] SSL_MONSEL_OFF = 12'h300;
  localparam logic [11:0] SSL_MONVAL_OFF = 12'h304;
  localparam logic [11:0] SSL_STATUS_OFF = 12'h308;
  // step field positions within one step block of five words
  localparam int unsigned SSL_F_IN1 = 0;
  localparam int unsigned SSL_F_IN2 = 1;
  localparam int unsigned SSL_F_OP = 2;
  localparam int unsigned SSL_F_TMODE = 3;
  localparam int unsigned SSL_F_TVAL = 4;
  // selection codes
  localparam logic [15:0] SSL_SEL_STEP = 16'h07d1;
  localparam logic [15:0] SSL_SEL_TERM = 16'h0fa1;
  localparam logic [15:0] SSL_SEL_STAT = 16'h1770;
  // operation codes
  localparam logic [3:0] SSL_OP_OFF = 4'h0;
  localparam logic [3:0] SSL_OP_THRU = 4'h1;
  localparam logic [3:0] SSL_OP_AND = 4'h2;
  localparam logic [3:0] SSL_OP_OR = 4'h3;
  localparam logic [3:0] SSL_OP_XOR = 4'h4;
  localparam logic [3:0] SSL_OP_SRST = 4'h5;
  localparam logic [3:0] SSL_OP_RSET = 4'h6;
  localparam logic [3:0] SSL_OP_RISE = 4'h7;
  localparam logic [3:0] SSL_OP_FALL = 4'h8;
  localparam logic [3:0] SSL_OP_EDGE = 4'h9;
  localparam logic [3:0] SSL_OP_NAND = 4'ha;
  localparam logic [3:0] SSL_OP_NOR = 4'hb;
  localparam logic [3:0] SSL_OP_CNT = 4'hc;
  // timer types
  localparam logic [2:0] SSL_TM_NONE = 3'h0;
  localparam logic [2:0] SSL_TM_ON = 3'h1;
  localparam logic [2:0] SSL_TM_OFF = 3'h2;
  localparam logic [2:0] SSL_TM_PULSE = 3'h3;
  localparam logic [2:0] SSL_TM_RETRIG = 3'h4;
  // reset values
  localparam logic SSL_MODE_RST = 1'b0;
  localparam logic [15:0] SSL_CFG_RST = 16'h0000;
endpackage

// >>> tb_ssl_engine.sv
// self-checking bench for the step sequence engine
// assumes apb with wait states and a 2 ms pass period
`timescale 1ns/1ps
module tb_ssl_engine;
  import ssl_pkg::*;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, engine_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [SSL_NTERM-1:0] term_in, term_cmd;
  logic [SSL_NSTAT-1:0] status_in, stat_cmd;
  logic [SSL_NOUT-1:0] engine_out;
  logic [SSL_NOUT*8-1:0] engine_out_function;
  logic e;
  int err_total, compares, cyc, n;
  ssl_engine u_ssl_engine (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .term_in(term_in), .status_in(status_in),
    .engine_out(engine_out), .engine_out_function(engine_out_function),
    .engine_active(engine_active));
  ssl_drive_model u_ssl_drive_model (.core_clk(core_clk), .reset(reset),
    .term_cmd(term_cmd), .stat_cmd(stat_cmd), .term_in(term_in), .status_in(status_in));
  always #50 core_clk = ~core_clk;
  // ************
  // tasks
  // ************
  task automatic wrap_up();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) err_total++;
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(e, 0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 0);
    chk(r, x);
  endtask
  function automatic logic [11:0] sa(input int k, input int f);
    return SSL_STEP_BASE + 12'(4 * (5 * (k - 1) + f));
  endfunction
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      wrap_up();
    end
  end
  // ************
  // main sequence
  // ************
  initial begin
    core_clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    term_cmd = 0; stat_cmd = 0; err_total = 0; compares = 0; cyc = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rd(SSL_MODE_OFF, 32'h0);
    apb(1'b0, 12'h0f0, 0);
    chk(e, 1);
    chk(r, 0);
    wr(sa(1, SSL_F_IN1), SSL_SEL_TERM);
    wr(sa(1, SSL_F_IN2), SSL_SEL_TERM + 1);
    wr(sa(1, SSL_F_OP), SSL_OP_AND);
    wr(sa(2, SSL_F_IN1), SSL_SEL_STEP);
    wr(sa(2, SSL_F_OP), SSL_OP_THRU);
    wr(sa(3, SSL_F_IN1), SSL_SEL_TERM);
    wr(sa(4, SSL_F_IN1), SSL_SEL_STAT);
    wr(sa(4, SSL_F_OP), SSL_OP_THRU);
    wr(sa(6, SSL_F_IN1), SSL_SEL_TERM);
    wr(sa(6, SSL_F_OP), SSL_OP_THRU);
    wr(sa(6, SSL_F_TMODE), SSL_TM_ON);
    wr(sa(6, SSL_F_TVAL), 32'h2);
    wr(SSL_OSRC_BASE, SSL_SEL_STEP + 1);
    wr(SSL_OSRC_BASE + 12'h4, SSL_SEL_STEP + 3);
    wr(SSL_OFUN_BASE, 32'h5a);
    rd(sa(2, SSL_F_IN1), SSL_SEL_STEP);
    for (int i = 12; i >= 0; i--) begin
      wr(sa(5, SSL_F_OP), i);
      rd(sa(5, SSL_F_OP), i);
    end
    for (int i = 4; i >= 0; i--) begin
      wr(sa(5, SSL_F_TMODE), i);
      rd(sa(5, SSL_F_TMODE), i);
    end
    wr(SSL_MONSEL_OFF, 32'h3);
    rd(SSL_MONSEL_OFF, 32'h3);
    term_cmd <= 11'h3;
    stat_cmd <= 8'h1;
    wr(SSL_MODE_OFF, 32'h1);
    n = 0;
    while (engine_out === 5'h0 && n < 45000) begin
      @(posedge core_clk);
      n++;
    end
    chk(engine_out, 5'h3);
    rd(SSL_STATUS_OFF, 32'h00b);
    chk(engine_out_function[7:0], 8'h5a);
    chk(engine_active, 1);
    wr(SSL_MONSEL_OFF, 32'h5);
    rd(SSL_MONVAL_OFF, 32'h1);
    term_cmd <= 11'h1;
    n = 0;
    while (engine_out === 5'h3 && n < 45000) begin
      @(posedge core_clk);
      n++;
    end
    chk(engine_out, 5'h2);
    rd(SSL_MONVAL_OFF, 32'h2);
    rd(SSL_STATUS_OFF, 32'h028);
    wr(SSL_MODE_OFF, 32'h0);
    repeat (3) @(posedge core_clk);
    chk(engine_out, 5'h0);
    chk(engine_active, 0);
    wrap_up();
  end
endmodule
